// ### ctch_host_model.sv
// i/o bus master model that programs and reads the channels
// assumes: the testbench calls its tasks; the device samples on rise
`timescale 1ns/100ps
module ctch_host_model (
    // clock
    input  wire logic       clk_i,
    // bus pins toward the device
    output logic      [1:0] sel_o,
    output logic            chip_en_n_o,
    output logic            io_request_n_o,
    output logic            read_n_o,
    output logic      [7:0] data_o,
    // answer from the device
    input  wire logic       data_oe_n_i
);
    // ************************************************************
    // bus cycles
    // ************************************************************
    task automatic release_bus();
        chip_en_n_o    = 1'b1;
        io_request_n_o = 1'b1;
        read_n_o       = 1'b1;
        data_o         = ~data_o;
        sel_o          = ~sel_o;
    endtask : release_bus

    task automatic bus_write(input logic [1:0] ch, input logic [7:0] d);
        @(negedge clk_i);
        sel_o          = ch;
        data_o         = d;
        chip_en_n_o    = 1'b0;
        io_request_n_o = 1'b0;
        read_n_o       = 1'b1;
        repeat (3) @(negedge clk_i);
        release_bus();
        repeat (2) @(negedge clk_i);
    endtask : bus_write

    task automatic bus_read(input logic [1:0] ch);
        int n;
        n = 0;
        @(negedge clk_i);
        sel_o          = ch;
        chip_en_n_o    = 1'b0;
        io_request_n_o = 1'b0;
        read_n_o       = 1'b0;
        while (data_oe_n_i !== 1'b0 && n < 10) begin
            @(negedge clk_i);
            n++;
        end
        @(negedge clk_i);
        release_bus();
        repeat (5) @(negedge clk_i);
    endtask : bus_read

    initial begin
        sel_o  = 2'h0;
        data_o = 8'h00;
        release_bus();
    end
endmodule : ctch_host_model

// ### ctch_pkg.sv
// constants shared by the counter/timer channel design
// assumes: single system clock, 8-bit i/o bus, four channels
package ctch_pkg;

    // ************************************************************
    // structure
    // ************************************************************
    localparam int CTCH_NUM_CH     = 4;
    localparam int CTCH_NUM_ZC     = 3;
    localparam int CTCH_DATA_W     = 8;
    localparam int CTCH_BUS_SYNC_W = 13;

    // ************************************************************
    // control word fields
    // ************************************************************
    localparam int CTCH_BIT_IS_CTRL  = 0;
    localparam int CTCH_BIT_SW_RESET = 1;
    localparam int CTCH_BIT_TC_NEXT  = 2;
    localparam int CTCH_BIT_TRIG_GO  = 3;
    localparam int CTCH_BIT_RISING   = 4;
    localparam int CTCH_BIT_DIV256   = 5;
    localparam int CTCH_BIT_COUNTER  = 6;
    localparam int CTCH_BIT_INT_EN   = 7;

    // ************************************************************
    // reset values and counts
    // ************************************************************
    localparam logic [7:0] CTCH_CTRL_RST   = 8'h00;
    localparam logic [7:0] CTCH_TC_RST     = 8'h00;
    localparam logic [7:0] CTCH_CNT_RST    = 8'h00;
    localparam logic [7:0] CTCH_VEC_RST    = 8'h00;
    localparam logic [7:0] CTCH_CNT_ONE    = 8'h01;
    localparam logic [7:0] CTCH_PRE_END16  = 8'h0F;
    localparam logic [7:0] CTCH_PRE_END256 = 8'hFF;
    localparam logic [7:0] CTCH_PRE_MASK16 = 8'h0F;
    localparam logic [4:0] CTCH_VEC_HI_RST = 5'h00;
    // bus synchroniser idle levels: strobes high, select and data low
    localparam logic [12:0] CTCH_BUS_SYNC_RST = 13'h0700;

    // ************************************************************
    // channel states
    // ************************************************************
    typedef enum logic [1:0] {
        CTCH_ST_IDLE  = 2'b00,
        CTCH_ST_ARMED = 2'b01,
        CTCH_ST_RUN   = 2'b10
    } ctch_state_t;

endpackage : ctch_pkg

// ### ctch_prescaler.sv
// prescaler of one channel: divides the system clock by 16 or 256
// assumes: clear_i restarts the division, run_i only in timer mode
`timescale 1ns/100ps
module ctch_prescaler
    import ctch_pkg::*;
(
    // clock and reset
    input  wire logic clk_i,
    input  wire logic nrst_i,
    // control
    input  wire logic clear_i,
    input  wire logic run_i,
    input  wire logic div256_i,
    // output pulse
    output logic      tick_o
);

    logic [7:0] pre_reg;
    logic [7:0] pre_next;
    logic       at_end;

    // ************************************************************
    // divider
    // ************************************************************
    always_comb begin
        if (div256_i) begin
            at_end = (pre_reg == CTCH_PRE_END256);
        end else begin
            at_end = ((pre_reg & CTCH_PRE_MASK16) == CTCH_PRE_END16);
        end
        tick_o = run_i && at_end;
        if (clear_i || !run_i) begin
            pre_next = '0;
        end else begin
            pre_next = pre_reg + 8'h01;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pre_reg <= '0;
        end else begin
            pre_reg <= pre_next;
        end
    end

endmodule : ctch_prescaler

// ### ctch_properties.sv
// assertions on the ports of the counter/timer top
// assumes: bound to ctch_top from the testbench
`timescale 1ns/100ps
module ctch_properties (
    // clock and reset
    input wire logic       CLK_I,
    input wire logic       NRST_I,
    // i/o bus
    input wire logic       CHIP_EN_N_I,
    input wire logic       IO_REQUEST_N_I,
    input wire logic       READ_N_I,
    input wire logic [7:0] DATA_O,
    input wire logic       DATA_OE_N_O,
    // channel outputs
    input wire logic [2:0] ZERO_COUNT_PULSE_O,
    input wire logic [3:0] INT_REQ_O,
    input wire logic [4:0] VECTOR_HI_O
);
    // ************************************************************
    // cycles since the last write strobe
    // ************************************************************
    logic [3:0] quiet_reg;
    logic [3:0] quiet_next;
    wire        wr_on = !IO_REQUEST_N_I && !CHIP_EN_N_I && READ_N_I;

    always_comb begin
        quiet_next = quiet_reg;
        if (wr_on) begin
            quiet_next = 4'h0;
        end else if (quiet_reg != 4'hF) begin
            quiet_next = quiet_reg + 4'h1;
        end
    end

    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            quiet_reg <= 4'h0;
        end else begin
            quiet_reg <= quiet_next;
        end
    end

    // ************************************************************
    // properties
    // ************************************************************
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!NRST_I);

    sequence rd_held;
        (!IO_REQUEST_N_I && !CHIP_EN_N_I && !READ_N_I) [*4];
    endsequence
    sequence bus_idle;
        IO_REQUEST_N_I [*4];
    endsequence
    sequence wr_held;
        wr_on [*3];
    endsequence

    chk_zc_one_cycle: assert property (
        (|ZERO_COUNT_PULSE_O) |=>
            (ZERO_COUNT_PULSE_O & $past(ZERO_COUNT_PULSE_O)) == 3'h0)
        else $error("zero-count pulse longer than one cycle");
    chk_irq_one_cycle: assert property (
        (|INT_REQ_O) |=> (INT_REQ_O & $past(INT_REQ_O)) == 4'h0)
        else $error("interrupt pulse longer than one cycle");
    chk_irq_with_zc: assert property (
        (INT_REQ_O[2:0] & ~ZERO_COUNT_PULSE_O) == 3'h0)
        else $error("interrupt without zero-count pulse");
    chk_read_drives: assert property (rd_held |=> !DATA_OE_N_O)
        else $error("bus not driven during read");
    chk_idle_release: assert property (bus_idle |=> DATA_OE_N_O)
        else $error("bus driven while idle");
    chk_write_quiet: assert property (wr_held |=> DATA_OE_N_O)
        else $error("bus driven during write");
    chk_vector_hold: assert property (
        (quiet_reg >= 4'h8) |-> $stable(VECTOR_HI_O))
        else $error("vector changed without a write");
    chk_data_hold: assert property (
        ($past(DATA_OE_N_O) && DATA_OE_N_O) |-> $stable(DATA_O))
        else $error("read data changed while not reading");
    chk_reset_quiet: assert property (
        $rose(NRST_I) |-> (ZERO_COUNT_PULSE_O == 3'h0 &&
            INT_REQ_O == 4'h0 && DATA_OE_N_O) [*2])
        else $error("outputs active right after reset");
endmodule : ctch_properties

// ### ctch_sync.sv
// two-stage synchroniser for a bundle of asynchronous inputs
// assumes: inputs may change at any time relative to clk_i
`timescale 1ns/100ps
module ctch_sync #(
    parameter int               WIDTH   = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             nrst_i,
    // data
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] meta_next;
    logic [WIDTH-1:0] sync_reg;
    logic [WIDTH-1:0] sync_next;

    always_comb begin
        meta_next = async_i;
        sync_next = meta_reg;
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            // reset to the idle level of the pins, no false strobe
            meta_reg <= RST_VAL;
            sync_reg <= RST_VAL;
        end else begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
        end
    end

    assign sync_o = sync_reg;

endmodule : ctch_sync

// ### ctch_top.sv
// four counter/timer channels behind an 8-bit i/o bus
// assumes: bus pins and trigger pins are asynchronous to CLK_I;
// assumes: the daisy chain outside latches the interrupt pulses
//
// Contract
// - each channel has 8-bit time constant, control, down-counter, prescaler
// - two channel select pins steer each access to channel 0 to 3
// - written byte with bit 0 set is control, clear is vector
// - control bit 7 set raises interrupt request at each zero count
// - counter mode counts trigger edges; bit 4 picks rising or falling
// - timer mode decrements on each prescaler output pulse
// - timer prescaler divides by 256 with bit 5 set, else 16
// - timer starts on time constant write, or on trigger if bit 3
// - with bit 2 set, next byte to that channel is time constant
// - time constant holds a count from 1 to 256
// - counter loads at start and reloads at every zero, then continues
// - new time constant takes effect only at the next reload
// - each zero count gives a high pulse on zero-count output
// - channels 0 to 2 have zero-count outputs; channel 3 none
// - a read returns the selected channel's down-counter
// - write needs request and enable active, read strobe inactive
`timescale 1ns/100ps
module ctch_top
    import ctch_pkg::*;
#(
    parameter int NUM_CH = CTCH_NUM_CH
) (
    // clock and reset
    input  wire logic        CLK_I,
    input  wire logic        NRST_I,
    // i/o bus
    input  wire logic        CHANNEL_SEL_LO_I,
    input  wire logic        CHANNEL_SEL_HI_I,
    input  wire logic        CHIP_EN_N_I,
    input  wire logic        IO_REQUEST_N_I,
    input  wire logic        READ_N_I,
    input  wire logic [7:0]  DATA_I,
    output logic      [7:0]  DATA_O,
    output logic             DATA_OE_N_O,
    // channel pins
    input  wire logic [3:0]  EXT_COUNT_TRIGGER_I,
    output logic      [2:0]  ZERO_COUNT_PULSE_O,
    // to interrupt logic
    output logic      [3:0]  INT_REQ_O,
    output logic      [4:0]  VECTOR_HI_O
);

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    logic [CTCH_BUS_SYNC_W-1:0] bus_async;
    logic [CTCH_BUS_SYNC_W-1:0] bus_sync;
    logic [3:0]                 trig_sync;
    logic                       sel_hi_s;
    logic                       sel_lo_s;
    logic                       chip_en_n_s;
    logic                       io_req_n_s;
    logic                       read_n_s;
    logic [7:0]                 data_s;

    assign bus_async = {CHANNEL_SEL_HI_I, CHANNEL_SEL_LO_I, CHIP_EN_N_I,
                        IO_REQUEST_N_I, READ_N_I, DATA_I};

    ctch_sync #(
        .WIDTH   (CTCH_BUS_SYNC_W),
        .RST_VAL (CTCH_BUS_SYNC_RST)
    ) u_bus_sync (
        .clk_i   (CLK_I),
        .nrst_i  (NRST_I),
        .async_i (bus_async),
        .sync_o  (bus_sync)
    );

    ctch_sync #(
        .WIDTH   (4)
    ) u_trig_sync (
        .clk_i   (CLK_I),
        .nrst_i  (NRST_I),
        .async_i (EXT_COUNT_TRIGGER_I),
        .sync_o  (trig_sync)
    );

    assign sel_hi_s    = bus_sync[12];
    assign sel_lo_s    = bus_sync[11];
    assign chip_en_n_s = bus_sync[10];
    assign io_req_n_s  = bus_sync[9];
    assign read_n_s    = bus_sync[8];
    assign data_s      = bus_sync[7:0];

    // ************************************************************
    // bus decode
    // ************************************************************
    logic       wr_act;
    logic       rd_act;
    logic       wr_pulse;
    logic [1:0] sel;
    logic       wr_prev_reg;
    logic       wr_prev_next;

    assign wr_act   = !io_req_n_s && !chip_en_n_s && read_n_s;
    assign rd_act   = !io_req_n_s && !chip_en_n_s && !read_n_s;
    assign wr_pulse = wr_act && !wr_prev_reg;
    assign sel      = {sel_hi_s, sel_lo_s};

    // ************************************************************
    // channel state
    // ************************************************************
    logic [7:0]  ctrl_reg     [NUM_CH];
    logic [7:0]  ctrl_next    [NUM_CH];
    logic [7:0]  tc_reg       [NUM_CH];
    logic [7:0]  tc_next      [NUM_CH];
    logic [7:0]  cnt_reg      [NUM_CH];
    logic [7:0]  cnt_next     [NUM_CH];
    ctch_state_t state_reg    [NUM_CH];
    ctch_state_t state_next   [NUM_CH];
    logic        tcpend_reg   [NUM_CH];
    logic        tcpend_next  [NUM_CH];
    logic [3:0]  trig_prev_reg;
    logic [3:0]  trig_prev_next;
    logic [3:0]  zc_reg;
    logic [3:0]  zc_next;
    logic [3:0]  irq_reg;
    logic [3:0]  irq_next;
    logic [3:0]  pre_clear;
    logic [3:0]  pre_run;
    logic [3:0]  pre_tick;
    logic [4:0]  vec_reg;
    logic [4:0]  vec_next;
    logic [7:0]  dout_reg;
    logic [7:0]  dout_next;
    logic        oe_n_reg;
    logic        oe_n_next;

    // decrement with reload; a reload value of zero gives 256 steps
    function automatic logic [8:0] count_step(input logic [7:0] cnt,
                                              input logic [7:0] tc);
        if (cnt == CTCH_CNT_ONE) begin
            count_step = {1'b1, tc};
        end else begin
            count_step = {1'b0, cnt - 8'h01};
        end
    endfunction : count_step

    // ************************************************************
    // prescalers
    // ************************************************************
    for (genvar g = 0; g < NUM_CH; g++) begin : g_pre
        assign pre_run[g] = (state_reg[g] == CTCH_ST_RUN) &&
                            !ctrl_reg[g][CTCH_BIT_COUNTER];
        ctch_prescaler u_pre (
            .clk_i    (CLK_I),
            .nrst_i   (NRST_I),
            .clear_i  (pre_clear[g]),
            .run_i    (pre_run[g]),
            .div256_i (ctrl_reg[g][CTCH_BIT_DIV256]),
            .tick_o   (pre_tick[g])
        );
    end

    // ************************************************************
    // next state of all channels
    // ************************************************************
    always_comb begin
        logic       rise;
        logic       fall;
        logic       edge_hit;
        logic       tick;
        logic [8:0] step;
        rise           = 1'b0;
        fall           = 1'b0;
        edge_hit       = 1'b0;
        tick           = 1'b0;
        step           = '0;
        wr_prev_next   = wr_act;
        trig_prev_next = trig_sync;
        vec_next       = vec_reg;
        pre_clear      = '0;
        zc_next        = '0;
        irq_next       = '0;
        for (int ch = 0; ch < NUM_CH; ch++) begin
            ctrl_next[ch]   = ctrl_reg[ch];
            tc_next[ch]     = tc_reg[ch];
            cnt_next[ch]    = cnt_reg[ch];
            state_next[ch]  = state_reg[ch];
            tcpend_next[ch] = tcpend_reg[ch];
            rise = trig_sync[ch] && !trig_prev_reg[ch];
            fall = !trig_sync[ch] && trig_prev_reg[ch];
            edge_hit = ctrl_reg[ch][CTCH_BIT_RISING] ? rise : fall;
            if (ctrl_reg[ch][CTCH_BIT_COUNTER]) begin
                tick = edge_hit;
            end else begin
                tick = pre_tick[ch];
            end
            unique case (state_reg[ch])
                CTCH_ST_IDLE: begin
                end
                CTCH_ST_ARMED: begin
                    if (edge_hit) begin
                        state_next[ch] = CTCH_ST_RUN;
                        pre_clear[ch]  = 1'b1;
                    end
                end
                CTCH_ST_RUN: begin
                    if (tick) begin
                        step         = count_step(cnt_reg[ch], tc_reg[ch]);
                        cnt_next[ch] = step[7:0];
                        zc_next[ch]  = step[8];
                        irq_next[ch] = step[8] &&
                                       ctrl_reg[ch][CTCH_BIT_INT_EN];
                    end
                end
                default: begin
                    state_next[ch] = CTCH_ST_IDLE;
                end
            endcase
            if (wr_pulse && (sel == ch[1:0])) begin
                if (tcpend_reg[ch]) begin
                    tc_next[ch]     = data_s;
                    tcpend_next[ch] = 1'b0;
                    if (state_reg[ch] == CTCH_ST_IDLE) begin
                        cnt_next[ch]  = data_s;
                        pre_clear[ch] = 1'b1;
                        if (!ctrl_reg[ch][CTCH_BIT_COUNTER] &&
                            ctrl_reg[ch][CTCH_BIT_TRIG_GO]) begin
                            state_next[ch] = CTCH_ST_ARMED;
                        end else begin
                            state_next[ch] = CTCH_ST_RUN;
                        end
                    end
                end else if (data_s[CTCH_BIT_IS_CTRL]) begin
                    ctrl_next[ch]   = data_s;
                    tcpend_next[ch] = data_s[CTCH_BIT_TC_NEXT];
                    if (data_s[CTCH_BIT_SW_RESET]) begin
                        state_next[ch] = CTCH_ST_IDLE;
                    end
                end else begin
                    vec_next = data_s[7:3];
                end
            end
        end
        oe_n_next = !rd_act;
        if (rd_act) begin
            dout_next = cnt_reg[sel];
        end else begin
            dout_next = dout_reg;
        end
    end

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            for (int ch = 0; ch < NUM_CH; ch++) begin
                ctrl_reg[ch]   <= CTCH_CTRL_RST;
                tc_reg[ch]     <= CTCH_TC_RST;
                cnt_reg[ch]    <= CTCH_CNT_RST;
                state_reg[ch]  <= CTCH_ST_IDLE;
                tcpend_reg[ch] <= 1'b0;
            end
            wr_prev_reg   <= 1'b0;
            trig_prev_reg <= '0;
            zc_reg        <= '0;
            irq_reg       <= '0;
            vec_reg       <= CTCH_VEC_HI_RST;
            dout_reg      <= CTCH_CNT_RST;
            oe_n_reg      <= 1'b1;
        end else begin
            for (int ch = 0; ch < NUM_CH; ch++) begin
                ctrl_reg[ch]   <= ctrl_next[ch];
                tc_reg[ch]     <= tc_next[ch];
                cnt_reg[ch]    <= cnt_next[ch];
                state_reg[ch]  <= state_next[ch];
                tcpend_reg[ch] <= tcpend_next[ch];
            end
            wr_prev_reg   <= wr_prev_next;
            trig_prev_reg <= trig_prev_next;
            zc_reg        <= zc_next;
            irq_reg       <= irq_next;
            vec_reg       <= vec_next;
            dout_reg      <= dout_next;
            oe_n_reg      <= oe_n_next;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign DATA_O             = dout_reg;
    assign DATA_OE_N_O        = oe_n_reg;
    assign ZERO_COUNT_PULSE_O = zc_reg[2:0];
    assign INT_REQ_O          = irq_reg;
    assign VECTOR_HI_O        = vec_reg;

endmodule : ctch_top

// ### testbench.sv
// self-checking testbench for the counter/timer top
// assumes: host model drives the bus, bench drives reset and triggers
`timescale 1ns/100ps
module testbench;
    logic       clk = 1'b0;
    logic       nrst;
    logic [1:0] sel;
    logic       ce_n;
    logic       io_request_n_n;
    logic       rd_n;
    logic [7:0] din;
    logic [7:0] dout;
    logic       oe_n;
    logic       oe_prev = 1'b1;
    logic [3:0] trig;
    logic [3:0] irq;
    logic [2:0] zc;
    logic [4:0] vec;
    logic [7:0] exp_rd[$];
    logic [6:0] exp_ev[$];
    int         fails = 0;
    int         n_tests = 0;
    int         seed = 42024;

    always #10 clk = ~clk;

    ctch_top ctch_top_i (.CLK_I(clk), .NRST_I(nrst),
        .CHANNEL_SEL_LO_I(sel[0]), .CHANNEL_SEL_HI_I(sel[1]),
        .CHIP_EN_N_I(ce_n), .IO_REQUEST_N_I(io_request_n_n), .READ_N_I(rd_n),
        .DATA_I(din), .DATA_O(dout), .DATA_OE_N_O(oe_n),
        .EXT_COUNT_TRIGGER_I(trig), .ZERO_COUNT_PULSE_O(zc),
        .INT_REQ_O(irq), .VECTOR_HI_O(vec));
    ctch_host_model ctch_host_model_i (.clk_i(clk), .sel_o(sel),
        .chip_en_n_o(ce_n), .io_request_n_o(io_request_n_n), .read_n_o(rd_n),
        .data_o(din), .data_oe_n_i(oe_n));

    // ************************************************************
    // compare, stimulus and closing tasks
    // ************************************************************
    task automatic cmp_byte(input logic [7:0] got, input logic [7:0] e);
        n_tests++;
        if (got !== e) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, e);
        end
    endtask : cmp_byte

    task automatic cmp_ev(input logic [6:0] got, input logic [6:0] e);
        n_tests++;
        if (got !== e) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, e);
        end
    endtask : cmp_ev

    task automatic wr(input logic [1:0] ch, input logic [7:0] d);
        ctch_host_model_i.bus_write(ch, d);
    endtask : wr

    task automatic rd(input logic [1:0] ch, input logic [7:0] e);
        exp_rd.push_back(e);
        ctch_host_model_i.bus_read(ch);
    endtask : rd

    task automatic ev(input int n, input logic [6:0] e);
        repeat (n) exp_ev.push_back(e);
    endtask : ev

    task automatic trg(input int ch, input logic lvl);
        @(negedge clk);
        trig[ch] = lvl;
        repeat (4) @(negedge clk);
    endtask : trg

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : report_and_stop

    // ************************************************************
    // result watcher
    // ************************************************************
    always @(negedge clk) begin
        oe_prev <= oe_n;
        if (nrst && oe_n === 1'b0 && oe_prev === 1'b1) begin
            cmp_byte(dout, exp_rd.size() ? exp_rd.pop_front() : 'x);
        end
        if (nrst && (|{irq, zc}) === 1'b1) begin
            cmp_ev({irq, zc}, exp_ev.size() ? exp_ev.pop_front() : 'x);
        end
    end

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        logic [7:0] v;
        nrst = 1'b0;
        trig = 4'h0;
        repeat (3) @(negedge clk);
        nrst = 1'b1;
        rd(2'h0, 8'h00);
        v = 8'($random(seed)) & 8'hF8;
        wr(2'($random(seed)), v);
        cmp_byte({3'h0, vec}, {3'h0, v[7:3]});
        wr(2'h0, 8'h85);
        wr(2'h0, 8'h02);
        ev(2, 7'h09);
        repeat (75) @(negedge clk);
        wr(2'h0, 8'h03);
        wr(2'h2, 8'hA5);
        wr(2'h2, 8'h01);
        ev(1, 7'h24);
        repeat (300) @(negedge clk);
        wr(2'h2, 8'h03);
        wr(2'h1, 8'h9D);
        wr(2'h1, 8'h01);
        repeat (50) @(negedge clk);
        ev(2, 7'h12);
        trg(1, 1'b1);
        repeat (36) @(negedge clk);
        wr(2'h1, 8'h03);
        trg(1, 1'b0);
        wr(2'h3, 8'hD5);
        wr(2'h3, 8'h03);
        trg(3, 1'b1);
        trg(3, 1'b0);
        rd(2'h3, 8'h02);
        wr(2'h3, 8'hD5);
        wr(2'h3, 8'h07);
        rd(2'h3, 8'h02);
        ev(1, 7'h40);
        repeat (2) begin
            trg(3, 1'b1);
            trg(3, 1'b0);
        end
        rd(2'h3, 8'h07);
        wr(2'h2, 8'h45);
        wr(2'h2, 8'h02);
        trg(2, 1'b1);
        rd(2'h2, 8'h02);
        trg(2, 1'b0);
        rd(2'h2, 8'h01);
        ev(1, 7'h04);
        trg(2, 1'b1);
        trg(2, 1'b0);
        rd(2'h2, 8'h02);
        wr(2'h0, 8'h55);
        wr(2'h0, 8'h00);
        rd(2'h0, 8'h00);
        trg(0, 1'b1);
        rd(2'h0, 8'hFF);
        trg(0, 1'b0);
        repeat (20) @(negedge clk);
        cmp_byte(8'(exp_ev.size() + exp_rd.size()), 8'h00);
        report_and_stop();
    end

    initial begin
        #(20 * 5000);
        fails++;
        report_and_stop();
    end
endmodule : testbench

bind ctch_top ctch_properties ctch_properties_i (
    .CLK_I(CLK_I), .NRST_I(NRST_I), .CHIP_EN_N_I(CHIP_EN_N_I),
    .IO_REQUEST_N_I(IO_REQUEST_N_I), .READ_N_I(READ_N_I),
    .DATA_O(DATA_O), .DATA_OE_N_O(DATA_OE_N_O),
    .ZERO_COUNT_PULSE_O(ZERO_COUNT_PULSE_O), .INT_REQ_O(INT_REQ_O),
    .VECTOR_HI_O(VECTOR_HI_O));
